// [rcf_pkg.sv]
// Shared constants and types for the reset cause flag bank
package rcf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int RCF_AW = 4;
   localparam int RCF_DW = 32;
   localparam int RCF_RW = 8;
   localparam int RCF_NF = 6;
   localparam int RCF_CW = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [3:0] RCF_OFS_FLAGS = 4'h0;
   localparam logic [3:0] RCF_OFS_CFG   = 4'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Flag index within the flag vector
   localparam int FI_BOR = 0;
   localparam int FI_POR = 1;
   localparam int FI_RI  = 2;
   localparam int FI_PIN = 3;
   localparam int FI_UNF = 4;
   localparam int FI_OVF = 5;

   // Register bit position of each flag, by flag index
   localparam logic [5:0][2:0] RCF_POS =
      {3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};

   // Unimplemented field
   localparam int RCF_RSV_HI = 5;
   localparam int RCF_RSV_LO = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Flag load values, index order ovf unf pin ri por bor
   localparam logic [5:0] RCF_RST_FLAGS = 6'h0d;
   localparam logic [5:0] RCF_BOR_MASK  = 6'h3d;
   localparam logic [5:0] RCF_BOR_VAL   = 6'h0c;
   localparam logic [5:0] RCF_SRC_VAL   = 6'h30;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register fields
   localparam int          RCF_CFG_STK = 0;
   localparam int          RCF_CFG_PIN = 1;
   localparam logic [1:0]  RCF_CFG_RST = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic borRst;
      logic resetInstr;
      logic stackOvf;
      logic stackUnf;
   } rcf_evt_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } rcf_avreq_t;

   typedef enum logic [1:0] {RS_RUN, RS_PULSE, RS_PIN} rcf_rst_state_t;

endpackage

// [rcf_flag_cell.sv]
// One reset cause flag with hardware priority over firmware
`timescale 1ns/1ns

module rcf_flag_cell
   import rcf_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Hardware update
   input  wire logic hwEv,
   input  wire logic hwVal,
   // Firmware update
   input  wire logic swWr,
   input  wire logic swVal,
   // Flag
   output logic      flag
);

   logic next_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Next value
   assign next_flag = hwEv ? hwVal : (swWr ? swVal : flag);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         flag <= RST_VAL;
      end else begin
         flag <= next_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_HW_WINS: assert property (
      @(posedge mclk) disable iff (!rstn)
      hwEv |=> flag == $past(hwVal))
      else $error("Hardware update lost to firmware write");

endmodule // rcf_flag_cell

// [rcf_reset_ctrl.sv]
// System reset request and pin hold sequencer
`timescale 1ns/1ns

module rcf_reset_ctrl
   import rcf_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Sources
   input  wire logic pinActive,
   input  wire logic trig,
   // Request
   output logic      sysResetOut
);

   rcf_rst_state_t state;
   rcf_rst_state_t next_state;
   logic           next_sysReset;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         RS_RUN: begin
            if (pinActive) begin
               next_state = RS_PIN;
            end else if (trig) begin
               next_state = RS_PULSE;
            end
         end
         RS_PULSE: begin
            next_state = pinActive ? RS_PIN : RS_RUN;
         end
         RS_PIN: begin
            if (!pinActive) begin
               next_state = RS_RUN;
            end
         end
         default: begin
            next_state = RS_RUN;
         end
      endcase
   end

   assign next_sysReset = (next_state != RS_RUN);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state       <= RS_RUN;
         sysResetOut <= 1'b0;
      end else begin
         state       <= next_state;
         sysResetOut <= next_sysReset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_PIN_HOLD: assert property (
      @(posedge mclk) disable iff (!rstn)
      pinActive |=> sysResetOut)
      else $error("Reset not held while pin is low");

   AST_PULSE_LEN: assert property (
      @(posedge mclk) disable iff (!rstn)
      (state == RS_RUN && trig && !pinActive) ##1 !pinActive
      |-> sysResetOut ##1 !sysResetOut)
      else $error("Reset pulse not one cycle long");

endmodule // rcf_reset_ctrl

// [rcf_top.sv]
// Reset cause flag register bank with Avalon-MM slave
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module rcf_top
   import rcf_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // Avalon-MM slave
   input  wire logic [RCF_AW-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [3:0]        avs_byteenable,
   input  wire logic [RCF_DW-1:0] avs_writedata,
   output logic      [RCF_DW-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   // Reset sources
   input  wire rcf_evt_t          hwEvtIn,
   input  wire logic              extResetPinN,
   // Reset request
   output logic                   sysResetOut
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   rcf_avreq_t              req;
   logic                    reqAny;
   logic                    ack;
   logic                    next_ack;
   logic                    wrAccept;
   logic                    selFlags;
   logic                    selCfg;
   logic                    lane0;
   logic                    flagWr;
   logic                    cfgWr;
   logic [RCF_DW-1:0]       rdData;
   logic [RCF_DW-1:0]       next_rdData;
   logic [RCF_CW-1:0]       cfgReg;
   logic [RCF_CW-1:0]       next_cfgReg;
   logic                    stkEn;
   logic                    pinEn;
   logic                    pinActive;
   logic                    borLoad;
   logic                    stkOvfEv;
   logic                    stkUnfEv;
   logic                    resetTrig;
   logic [RCF_NF-1:0]       srcEv;
   logic [RCF_NF-1:0]       hwEv;
   logic [RCF_NF-1:0]       hwVal;
   logic [RCF_NF-1:0]       wrVal;
   logic [RCF_NF-1:0]       flags;
   logic [RCF_RW-1:0]       regBits;
   logic [RCF_DW-1:0]       flagsWord;
   logic [RCF_DW-1:0]       cfgWord;

   ////////////////////////////////////////////////////////////////////////////
   // Bus request carrier
   assign req.read       = avs_read;
   assign req.write      = avs_write;
   assign req.address    = avs_address;
   assign req.byteenable = avs_byteenable;
   assign req.writedata  = avs_writedata;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake: one wait cycle, answer on the second
   assign reqAny          = req.read | req.write;
   assign next_ack        = reqAny & ~ack;
   assign avs_waitrequest = reqAny & ~ack;
   assign wrAccept        = req.write & ack;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ack <= 1'b0;
      end else begin
         ack <= next_ack;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign selFlags = (req.address == RCF_OFS_FLAGS);
   assign selCfg   = (req.address == RCF_OFS_CFG);
   assign lane0    = req.byteenable[0];
   assign flagWr   = wrAccept & selFlags & lane0;
   assign cfgWr    = wrAccept & selCfg & lane0;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   assign flagsWord = {{(RCF_DW-RCF_RW){1'b0}}, regBits};
   assign cfgWord   = {{(RCF_DW-RCF_CW){1'b0}}, cfgReg};

   assign next_rdData = !(req.read & ~ack) ? rdData :
                        selFlags ? flagsWord :
                        selCfg ? cfgWord :
                        {RCF_DW{1'b0}};

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdData <= {RCF_DW{1'b0}};
      end else begin
         rdData <= next_rdData;
      end
   end

   assign avs_readdata = rdData;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register
   assign next_cfgReg = cfgWr ? req.writedata[RCF_CW-1:0] : cfgReg;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfgReg <= RCF_CFG_RST;
      end else begin
         cfgReg <= next_cfgReg;
      end
   end

   assign stkEn = cfgReg[RCF_CFG_STK];
   assign pinEn = cfgReg[RCF_CFG_PIN];

   ////////////////////////////////////////////////////////////////////////////
   // Hardware reset sources
   assign pinActive = pinEn & ~extResetPinN;
   assign borLoad   = hwEvtIn.borRst;
   assign stkOvfEv  = hwEvtIn.stackOvf & stkEn;
   assign stkUnfEv  = hwEvtIn.stackUnf & stkEn;
   assign resetTrig = borLoad | hwEvtIn.resetInstr | stkOvfEv | stkUnfEv;

   assign srcEv[FI_OVF] = stkOvfEv;
   assign srcEv[FI_UNF] = stkUnfEv;
   assign srcEv[FI_PIN] = pinActive;
   assign srcEv[FI_RI]  = hwEvtIn.resetInstr;
   assign srcEv[FI_POR] = 1'b0;
   assign srcEv[FI_BOR] = 1'b0;

   // Brown-out load outranks single sources
   assign hwEv  = srcEv | ({RCF_NF{borLoad}} & RCF_BOR_MASK);
   assign hwVal = borLoad ? RCF_BOR_VAL : RCF_SRC_VAL;

   ////////////////////////////////////////////////////////////////////////////
   // Flag cells and register image
   assign regBits[RCF_RSV_HI:RCF_RSV_LO] = 2'h0;

   generate
      for (genvar i = 0; i < RCF_NF; i++) begin : gFlag
         assign wrVal[i] = req.writedata[RCF_POS[i]];

         rcf_flag_cell #(
            .RST_VAL (RCF_RST_FLAGS[i])
         ) uCell (
            .mclk  (mclk),
            .rstn  (rstn),
            .hwEv  (hwEv[i]),
            .hwVal (hwVal[i]),
            .swWr  (flagWr),
            .swVal (wrVal[i]),
            .flag  (flags[i])
         );

         assign regBits[RCF_POS[i]] = flags[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Reset request sequencer
   rcf_reset_ctrl uRst (
      .mclk        (mclk),
      .rstn        (rstn),
      .pinActive   (pinActive),
      .trig        (resetTrig),
      .sysResetOut (sysResetOut)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking

   default disable iff (!rstn);

   sequence sReqWait;
      reqAny && avs_waitrequest;
   endsequence

   sequence sAnswer;
      reqAny && !avs_waitrequest;
   endsequence

   sequence sIdleTrig;
      !sysResetOut ##1 !pinActive;
   endsequence

   sequence sBorLoaded;
      flags[FI_OVF] == 1'b0 && flags[FI_UNF] == 1'b0 &&
      flags[FI_PIN] == 1'b1 && flags[FI_RI] == 1'b1 &&
      flags[FI_BOR] == 1'b0;
   endsequence

   AST_BUS_ANSWER: assert property (
      sReqWait |=> sAnswer)
      else $error("Bus answer not given after one wait cycle");

   AST_OVF_SET: assert property (
      hwEvtIn.stackOvf && stkEn && !borLoad |=> flags[FI_OVF])
      else $error("Overflow flag not set");

   AST_UNF_SET: assert property (
      hwEvtIn.stackUnf && stkEn && !borLoad |=> flags[FI_UNF])
      else $error("Underflow flag not set");

   AST_STK_GATED: assert property (
      !stkEn && !borLoad && !flagWr
      |=> $stable(flags[FI_OVF:FI_UNF]))
      else $error("Stack flag changed while faults disabled");

   AST_PIN_CLR: assert property (
      pinActive && !borLoad |=> !flags[FI_PIN])
      else $error("Pin flag not cleared by pin reset");

   AST_RI_CLR: assert property (
      hwEvtIn.resetInstr && !borLoad |=> !flags[FI_RI])
      else $error("Instruction flag not cleared");

   AST_BOR_LOAD: assert property (
      borLoad && !flagWr |=> sBorLoaded and $stable(flags[FI_POR]))
      else $error("Brown-out load values wrong");

   AST_POR_LOAD: assert property (
      $rose(rstn) |-> flags == RCF_RST_FLAGS)
      else $error("Power-on load values wrong");

   AST_RSVD_ZERO: assert property (
      sAnswer ##0 req.read && selFlags
      |-> avs_readdata[RCF_RSV_HI:RCF_RSV_LO] == 2'h0 &&
          avs_readdata[RCF_DW-1:RCF_RW] == 24'h0)
      else $error("Unimplemented bits read nonzero");

   AST_FW_WRITE: assert property (
      flagWr && hwEv == 6'h0 |=> flags == $past(wrVal))
      else $error("Firmware flag write not taken");

   AST_READ_BACK: assert property (
      sAnswer ##0 req.read && selFlags ##0 !(|hwEv) && !flagWr
      |=> ##1 (!(reqAny && selFlags && req.read) ||
               avs_waitrequest ||
               avs_readdata[RCF_RW-1:0] == $past(regBits, 1)))
      else $error("Flag readback mismatch");

   AST_BOR_REQ: assert property (
      borLoad ##0 sIdleTrig |-> sysResetOut)
      else $error("No reset request on brown-out");

   AST_UNMAP_RD: assert property (
      sAnswer ##0 req.read && !selFlags && !selCfg
      |-> avs_readdata == {RCF_DW{1'b0}})
      else $error("Unmapped read not zero");

   AST_CFG_RD: assert property (
      sAnswer ##0 req.read && selCfg
      |-> avs_readdata[RCF_DW-1:RCF_CW] == 30'h0)
      else $error("Config high bits read nonzero");

   AST_RD_HOLD: assert property (
      !(req.read && !ack) |=> $stable(avs_readdata))
      else $error("Read data moved without a read");

   AST_CFG_WR: assert property (
      cfgWr |=> cfgReg == $past(req.writedata[RCF_CW-1:0]))
      else $error("Config write not taken");

   AST_LANE_OFF: assert property (
      wrAccept && !lane0 && hwEv == 6'h0 |=> $stable(flags))
      else $error("Flags changed by a write with lane 0 off");

   AST_UNMAP_WR: assert property (
      wrAccept && !selFlags && !selCfg && hwEv == 6'h0
      |=> $stable(flags) && $stable(cfgReg))
      else $error("Unmapped write changed a register");

   AST_POR_FW_ONLY: assert property (
      !flagWr |=> $stable(flags[FI_POR]))
      else $error("Power-on flag changed by hardware");

   AST_PIN_GATED: assert property (
      !pinEn && !borLoad && !flagWr |=> $stable(flags[FI_PIN]))
      else $error("Pin flag changed while pin disabled");

   AST_RI_HOLD: assert property (
      !hwEvtIn.resetInstr && !borLoad && !flagWr |=> $stable(flags[FI_RI]))
      else $error("Instruction flag changed with no event");

   AST_OVF_KEEP: assert property (
      flags[FI_OVF] && !borLoad && !flagWr |=> flags[FI_OVF])
      else $error("Overflow flag cleared by hardware");

   AST_UNF_KEEP: assert property (
      flags[FI_UNF] && !borLoad && !flagWr |=> flags[FI_UNF])
      else $error("Underflow flag cleared by hardware");

   AST_PIN_NO_SET: assert property (
      !flags[FI_PIN] && !borLoad && !flagWr |=> !flags[FI_PIN])
      else $error("Pin flag set by hardware");

   AST_BOR_NO_SET: assert property (
      !flags[FI_BOR] && !flagWr |=> !flags[FI_BOR])
      else $error("Brown-out flag set by hardware");

   AST_STK_REQ: assert property (
      (stkOvfEv || stkUnfEv) ##0 sIdleTrig |-> sysResetOut)
      else $error("No reset request on stack fault");

   AST_STK_QUIET: assert property (
      !stkEn && !borLoad && !hwEvtIn.resetInstr && !pinActive && !sysResetOut
      |=> !sysResetOut)
      else $error("Reset request while stack faults disabled");

   AST_RI_REQ: assert property (
      hwEvtIn.resetInstr ##0 sIdleTrig |-> sysResetOut)
      else $error("No reset request on reset instruction");

   AST_PIN_DROP: assert property (
      sysResetOut && !pinActive |=> !sysResetOut)
      else $error("Reset request not dropped after pin release");

endmodule // rcf_top

// [tb_top.sv]
// Self-checking testbench for the reset cause flag bank
`timescale 1ns/1ns

`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin \
   err_total++; $display("CHECK FAILED at %0t: got %h expected %h", \
   $time, act, exp); end end

module tb_top
   import rcf_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////////
   // Signals
   logic              mclk;
   logic              rstn;
   logic [RCF_AW-1:0] avsAddr;
   logic              avsRd;
   logic              avsWr;
   logic [3:0]        avsBe;
   logic [RCF_DW-1:0] avsWd;
   logic [RCF_DW-1:0] avsRdData;
   logic              avsWait;
   rcf_evt_t          evt;
   logic              pinN;
   logic              sysRst;
   int                err_total;
   int                num_checks;
   int                cycles;

   rcf_top rcf_top_i (
      .mclk            (mclk),
      .rstn            (rstn),
      .avs_address     (avsAddr),
      .avs_read        (avsRd),
      .avs_write       (avsWr),
      .avs_byteenable  (avsBe),
      .avs_writedata   (avsWd),
      .avs_readdata    (avsRdData),
      .avs_waitrequest (avsWait),
      .hwEvtIn         (evt),
      .extResetPinN    (pinN),
      .sysResetOut     (sysRst)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock, timeout, verdict
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   task automatic close_out();
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 3000) begin
         err_total++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks
   // Hold the request until waitrequest is sampled low at a rising edge
   task automatic wait_ack(output logic [RCF_DW-1:0] d);
      do begin
         @(posedge mclk);
      end while (avsWait !== 1'b0);
      d = avsRdData;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d,
                         input logic [3:0] be = 4'hf);
      logic [RCF_DW-1:0] dummy;
      @(posedge mclk);
      avsAddr <= a;
      avsWd   <= {24'hffffff, d};
      avsBe   <= be;
      avsWr   <= 1'b1;
      wait_ack(dummy);
      avsWr   <= 1'b0;
   endtask

   task automatic chk_rd(input logic [3:0] a, input logic [31:0] exp);
      logic [RCF_DW-1:0] d;
      @(posedge mclk);
      avsAddr <= a;
      avsRd   <= 1'b1;
      wait_ack(d);
      avsRd   <= 1'b0;
      `CHK(d, exp)
   endtask

   // Pulse events, then see a one-cycle reset request or none
   task automatic pulse(input rcf_evt_t e, input logic expRst);
      @(posedge mclk);
      evt <= e;
      @(posedge mclk);
      evt <= '0;
      #1;
      `CHK(sysRst, expRst)
      @(posedge mclk);
      #1;
      `CHK(sysRst, 1'b0)
   endtask

   // Hold the pin low for five cycles
   task automatic pin_low(input logic expRst);
      @(posedge mclk);
      pinN <= 1'b0;
      repeat (4) begin
         @(posedge mclk);
         #1;
         `CHK(sysRst, expRst)
      end
      @(posedge mclk);
      pinN <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK(sysRst, 1'b0)
   endtask

   task automatic do_reset();
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'b0;
      avsAddr = '0;
      avsRd = 1'b0;
      avsWr = 1'b0;
      avsBe = '0;
      avsWd = '0;
      evt = '0;
      pinN = 1'b1;
      err_total = 0;
      num_checks = 0;
      cycles = 0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      // Reset values and refused accesses
      chk_rd(RCF_OFS_FLAGS, 32'h0000000d);
      chk_rd(RCF_OFS_CFG, 32'h00000003);
      chk_rd(4'h8, 32'h00000000);
      bus_wr(4'h8, 8'hff);
      bus_wr(RCF_OFS_FLAGS, 8'hf0, 4'h0);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000d);
      // Firmware access to every flag
      bus_wr(RCF_OFS_FLAGS, 8'hff);
      chk_rd(RCF_OFS_FLAGS, 32'h000000cf);
      bus_wr(RCF_OFS_FLAGS, 8'h30);
      chk_rd(RCF_OFS_FLAGS, 32'h00000000);
      bus_wr(RCF_OFS_FLAGS, 8'h0f);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000f);
      // Stack faults
      pulse('{borRst:1'b0, resetInstr:1'b0, stackOvf:1'b1, stackUnf:1'b0},
            1'b1);
      chk_rd(RCF_OFS_FLAGS, 32'h0000008f);
      pulse('{borRst:1'b0, resetInstr:1'b0, stackOvf:1'b0, stackUnf:1'b1},
            1'b1);
      chk_rd(RCF_OFS_FLAGS, 32'h000000cf);
      bus_wr(RCF_OFS_FLAGS, 8'h0f);
      bus_wr(RCF_OFS_CFG, 8'h02);
      pulse('{borRst:1'b0, resetInstr:1'b0, stackOvf:1'b1, stackUnf:1'b1},
            1'b0);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000f);
      bus_wr(RCF_OFS_CFG, 8'h03);
      chk_rd(RCF_OFS_CFG, 32'h00000003);
      // Reset instruction
      pulse('{borRst:1'b0, resetInstr:1'b1, stackOvf:1'b0, stackUnf:1'b0},
            1'b1);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000b);
      bus_wr(RCF_OFS_FLAGS, 8'h0f);
      // Pin reset, enabled then disabled
      pin_low(1'b1);
      chk_rd(RCF_OFS_FLAGS, 32'h00000007);
      bus_wr(RCF_OFS_FLAGS, 8'h0f);
      bus_wr(RCF_OFS_CFG, 8'h01);
      pin_low(1'b0);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000f);
      bus_wr(RCF_OFS_CFG, 8'h03);
      // Brown-out load
      bus_wr(RCF_OFS_FLAGS, 8'hc3);
      pulse('{borRst:1'b1, resetInstr:1'b0, stackOvf:1'b0, stackUnf:1'b0},
            1'b1);
      chk_rd(RCF_OFS_FLAGS, 32'h0000000e);
      // Hardware event beats a firmware clear in the same cycle
      @(posedge mclk);
      evt <= '{borRst:1'b0, resetInstr:1'b0, stackOvf:1'b1, stackUnf:1'b0};
      bus_wr(RCF_OFS_FLAGS, 8'h00);
      evt <= '0;
      repeat (2) @(posedge mclk);
      chk_rd(RCF_OFS_FLAGS, 32'h00000080);
      // Power-on reset in mid-run
      bus_wr(RCF_OFS_FLAGS, 8'hcf);
      do_reset();
      chk_rd(RCF_OFS_FLAGS, 32'h0000000d);
      close_out();
   end

endmodule // tb_top
